//--- event_source.sv
/*
 * Model of the sources beside the timer block: two event inputs and the
 * subsystem clock. Edges sit 3 ns off the main clock grid, so each one
 * crosses asynchronously yet at a fixed phase, keeping intervals exact.
 */
`timescale 1ns/1ns

// Free-running square waves, each with its own half period in ns.
module event_source #(
    parameter int HALF_A = 100,
    parameter int HALF_B = 120,
    parameter int HALF_S = 200
) (
    output logic timerAEventInput,
    output logic timerBEventInput,
    output logic subClockInput
);
    // All sources start low and then toggle for the whole run.
    initial begin
        timerAEventInput = 1'b0;
        timerBEventInput = 1'b0;
        subClockInput    = 1'b0;
        #3;
        fork
            forever #(HALF_A) timerAEventInput = ~timerAEventInput;
            forever #(HALF_B) timerBEventInput = ~timerBEventInput;
            forever #(HALF_S) subClockInput = ~subClockInput;
        join
    end
endmodule

//--- test_triple_timer_mode_control.sv
/*
 * Self-checking bench for the three-timer mode control block.
 * Assumes the event source model and the bound checker beside it.
 */
`timescale 1ns/1ns

bind triple_timer_mode_control triple_timer_asserts u_triple_timer_asserts (.*);

module test_triple_timer_mode_control
    import triple_timer_pkg::*;
;
    localparam int HA = 100;
    localparam int HB = 120;
    localparam int HS = 200;
    logic        clk, reset_n, byteWrite, bitWrite, bitValue, readStrobe;
    logic [15:0] busAddr;
    logic [7:0]  byteData, readData, countRegisterA, countRegisterB;
    logic [7:0]  countRegisterC, cmpV [3];
    logic [2:0]  bitIndex, portPinValue, matchIrq, pinOut, pinOutEnable_n;
    logic        timerAEventInput, timerBEventInput, subClockInput, rdPend;
    logic        pinPrev, pwmOn;
    logic [7:0]  rdQ [$];
    logic [15:0] ivQ [$];
    logic [15:0] adr [3] = '{TIMER_A_MODE_ADDR, TIMER_B_MODE_ADDR,
        TIMER_C_MODE_ADDR};
    int          dv [3][4] = '{'{1, 8, HA / 5, HA / 5},
        '{16, 256, HB / 5, HB / 5}, '{32, 128, HS / 5, 0}};
    int          errors, comparisons, cyc, last, watch, t, s;
    integer      seed;
    wire logic [7:0] compareValueA = cmpV[0];
    wire logic [7:0] compareValueB = cmpV[1];
    wire logic [7:0] compareValueC = cmpV[2];

    triple_timer_mode_control u_triple_timer_mode_control (.*);
    event_source #(.HALF_A(HA), .HALF_B(HB), .HALF_S(HS)) u_event_source (.*);

    always #5 clk = ~clk;

    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Byte store, bit store and read, each held for one clock edge.
    // An idle edge follows each one, so a strobe never drops and rises
    // again in the same time step.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        busAddr = a;
        byteData = d;
        byteWrite = 1'b1;
        @(posedge clk);
        #1 byteWrite = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic bw(input logic [15:0] a, input logic [2:0] i, v);
        busAddr = a;
        bitIndex = i;
        bitValue = v;
        bitWrite = 1'b1;
        @(posedge clk);
        #1 bitWrite = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        busAddr = a;
        readStrobe = 1'b1;
        rdQ.push_back(e);
        @(posedge clk);
        #1 readStrobe = 1'b0;
        @(posedge clk);
        #1;
    endtask

    function automatic logic [7:0] cnt(input int i);
        return i == 0 ? countRegisterA : i == 1 ? countRegisterB :
            countRegisterC;
    endfunction

    // Configures a stopped timer, runs it and notes the match interval.
    task automatic run(input int i, input int c, input logic p);
        logic [7:0] m;
        int         k;
        cmpV[i] = 8'h01 + 8'($random(seed) & 3);
        m = {1'b0, p, 3'h0, 2'(c), 1'($random(seed))};
        wr(adr[i], m);
        wr(adr[i], m | 8'h80);
        chk("pinOutEnable_n", 16'(!m[0]), 16'(pinOutEnable_n[i]));
        pwmOn = p;
        watch = i;
        ivQ.push_back(16'(p ? 256 * dv[i][c] : (cmpV[i] + 1) * dv[i][c]));
        for (k = 0; k < 10000 && ivQ.size() > 0; k++) @(posedge clk);
        #1 chk("pending", 16'h0, 16'(ivQ.size()));
        ivQ.delete();
        wr(adr[i], 8'h00);
        @(posedge clk);
        #1 chk("count", 16'h0, cnt(i));
    endtask

    // Takes the oldest note whenever a read, or any match after a run's first one, shows up.
    // At a match the pin still shows the output from before that match:
    // it alternates in normal mode and is high after the wrap in PWM mode.
    always @(posedge clk) begin
        if (rdPend) chk("readData", rdQ.pop_front(), readData);
        rdPend = readStrobe;
        cyc++;
        if (ivQ.size() == 0) last = -1;
        else if (matchIrq[watch] === 1'b1) begin
            if (last >= 0) begin
                chk("interval", ivQ.pop_front(),
                    16'(cyc - last));
                if (pinOutEnable_n[watch] === 1'b0)
                    chk("pinOut", pwmOn ? 16'h1 : 16'(!pinPrev),
                        16'(pinOut[watch]));
            end
            pinPrev = pinOut[watch];
            last = cyc;
        end
    end

    // Random ordinary port values, changed just after each edge.
    always @(posedge clk) #1 portPinValue = 3'($random(seed));

    // Cuts a hang short after well over the expected run length.
    initial begin
        #800000;
        errors++;
        tally_and_finish;
    end

    // Main sequence: register access, every clock source, then refusals.
    initial begin
        seed = 32'hE610;
        {clk, reset_n, byteWrite, bitWrite, bitValue, readStrobe} = 6'h00;
        {busAddr, byteData, bitIndex, portPinValue, rdPend} = 31'h0;
        cmpV = '{8'h01, 8'h01, 8'h01};
        {errors, comparisons, cyc, watch} = {32'h0, 32'h0, 32'h0, 32'h0};
        last = -1;
        {pinPrev, pwmOn} = 2'h0;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        for (t = 0; t < 3; t++) rd(adr[t], 8'h00);
        for (t = 0; t < 3; t++) begin
            // Clock code 01 keeps timer C off its forbidden setting.
            wr(adr[t], 8'hFB);
            rd(adr[t], 8'hC3);
            bw(adr[t], 3'h7, 1'b0);
            bw(adr[t], 3'h4, 1'b1);
            rd(adr[t], 8'h43);
            wr(adr[t], 8'h00);
        end
        wr(16'hFF54, 8'hFF);
        rd(16'hFF54, 8'h00);
        rd(adr[0], 8'h00);
        for (t = 0; t < 3; t++)
            for (s = 0; s < 4; s++)
                if (t < 2 || s < 3) run(t, s, 1'b0);
        run(0, 0, 1'b1);
        run(1, 0, 1'b1);
        wr(adr[2], 8'h06);
        wr(adr[2], 8'h86);
        repeat (300) @(posedge clk);
        #1 chk("countRegisterC", 16'h0, countRegisterC);
        tally_and_finish;
    end
endmodule

//--- triple_timer_asserts.sv
/*
 * Checker for the three-timer mode control block, bound to its ports.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/1ns

// Ties the block's outputs to the bus requests and inputs that cause them.
module triple_timer_asserts
    import triple_timer_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire logic [ADDR_WIDTH-1:0] busAddr,
    input wire logic                  byteWrite,
    input wire logic                  bitWrite,
    input wire logic                  readStrobe,
    input wire logic [7:0]            readData,
    input wire logic [7:0]            compareValueA,
    input wire logic [2:0]            portPinValue,
    input wire logic [7:0]            countRegisterA,
    input wire logic [2:0]            matchIrq,
    input wire logic [2:0]            pinOut,
    input wire logic [2:0]            pinOutEnable_n
);
    // All checks share the main clock and its reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic mapped = busAddr inside {TIMER_A_MODE_ADDR,
        TIMER_B_MODE_ADDR, TIMER_C_MODE_ADDR};

    rst_state_a: assert property ($rose(reset_n) |->
        countRegisterA == 8'h00 && pinOutEnable_n == 3'h7)
        else $error("Outputs not in reset state.");
    unmap_read_a: assert property (readStrobe && !mapped |=>
        readData == 8'h00) else $error("Unmapped read not zero.");
    zero_bits_a: assert property (readStrobe |=>
        readData[5:3] == 3'h0) else $error("Bits 5 to 3 not zero.");
    count_step_a: assert property (countRegisterA !=
        $past(countRegisterA) |-> countRegisterA == 8'h00 ||
        countRegisterA == $past(countRegisterA) + 8'h01)
        else $error("Counter A jumped.");
    match_cause_a: assert property (matchIrq[0] |->
        $past(countRegisterA) == $past(compareValueA))
        else $error("Match A without equal count.");
    irq_pulse_a: assert property (matchIrq[1] |=>
        !matchIrq[1]) else $error("Match B longer than a cycle.");
    pin_port_a: assert property ($past(reset_n) |->
        (pinOut & $past(pinOutEnable_n)) ==
        ($past(portPinValue) & $past(pinOutEnable_n)))
        else $error("Port value not on pin.");
    oe_write_a: assert property ($changed(pinOutEnable_n[0]) |->
        $past((byteWrite || bitWrite) && busAddr == TIMER_A_MODE_ADDR))
        else $error("Pin A enable changed without store.");
endmodule

//--- triple_timer_mode_control.sv
/*
 * Mode control and count datapath for three 8-bit timers. Each timer has
 * a mode control register reached by byte or single-bit stores, a counter
 * that clears on a compare match except in PWM mode, and an output stage routed to a shared
 * pin. Assumes the external event inputs and the subsystem clock arrive
 * asynchronously and are much slower than clk; port logic supplies the
 * ordinary pin values that are shown when a timer output is disabled.
 */
`timescale 1ns/1ns

module triple_timer_mode_control
    import triple_timer_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [ADDR_WIDTH-1:0] busAddr,
    input  wire logic                  byteWrite,
    input  wire logic [7:0]            byteData,
    input  wire logic                  bitWrite,
    input  wire logic [2:0]            bitIndex,
    input  wire logic                  bitValue,
    input  wire logic                  readStrobe,
    output logic      [7:0]            readData,
    input  wire logic [7:0]            compareValueA,
    input  wire logic [7:0]            compareValueB,
    input  wire logic [7:0]            compareValueC,
    input  wire logic                  timerAEventInput,
    input  wire logic                  timerBEventInput,
    input  wire logic                  subClockInput,
    input  wire logic [2:0]            portPinValue,
    output logic      [7:0]            countRegisterA,
    output logic      [7:0]            countRegisterB,
    output logic      [7:0]            countRegisterC,
    output logic      [2:0]            matchIrq,
    output logic      [2:0]            pinOut,
    output logic      [2:0]            pinOutEnable_n
);

    logic [7:0]                modeReg [NUM_TIMERS];
    logic [7:0]                countReg [NUM_TIMERS];
    logic [2:0]                matchIrqReg;
    logic [2:0]                timerOutReg;
    logic [2:0]                pinOutReg;
    logic [PRESCALE_WIDTH-1:0] prescaleReg;
    logic [2:0]                syncStage1Reg;
    logic [2:0]                syncStage2Reg;
    logic [2:0]                syncStage3Reg;
    logic [7:0]                readDataReg;

    // Address decode of the three mode registers.
    wire logic [2:0] addrHit;
    assign addrHit[0] = (busAddr == TIMER_A_MODE_ADDR);
    assign addrHit[1] = (busAddr == TIMER_B_MODE_ADDR);
    assign addrHit[2] = (busAddr == TIMER_C_MODE_ADDR);

    // Read multiplexer; unmapped addresses read as zero.
    wire logic [7:0] readSelect;
    assign readSelect = addrHit[0] ? modeReg[0] :
                        addrHit[1] ? modeReg[1] :
                        addrHit[2] ? modeReg[2] : 8'h00;

    // Prescaler taps: one-cycle enables at each divided rate.
    wire logic tickDivA;
    wire logic tickDivB0;
    wire logic tickDivB1;
    wire logic tickDivC0;
    wire logic tickDivC1;
    assign tickDivA  = &prescaleReg[DIV_A_LOG2-1:0];
    assign tickDivB0 = &prescaleReg[DIV_B0_LOG2-1:0];
    assign tickDivB1 = &prescaleReg[DIV_B1_LOG2-1:0];
    assign tickDivC0 = &prescaleReg[DIV_C0_LOG2-1:0];
    assign tickDivC1 = &prescaleReg[DIV_C1_LOG2-1:0];

    // Edge detection on the synchronised inputs, second and third stages.
    wire logic [2:0] riseEdge;
    wire logic [2:0] fallEdge;
    assign riseEdge = syncStage2Reg & ~syncStage3Reg;
    assign fallEdge = ~syncStage2Reg & syncStage3Reg;

    // Clock selection fields of each timer.
    wire logic [1:0] clkSel [NUM_TIMERS];
    assign clkSel[0] = modeReg[0][CLKSEL_HI_BIT:CLKSEL_LO_BIT];
    assign clkSel[1] = modeReg[1][CLKSEL_HI_BIT:CLKSEL_LO_BIT];
    assign clkSel[2] = modeReg[2][CLKSEL_HI_BIT:CLKSEL_LO_BIT];

    // Count enable per timer from its selected count clock.
    wire logic [2:0] countTick;
    assign countTick[0] = (clkSel[0] == CLKSEL_00) ? 1'b1 :
                          (clkSel[0] == CLKSEL_01) ? tickDivA :
                          (clkSel[0] == CLKSEL_10) ? riseEdge[0] :
                                                     fallEdge[0];
    assign countTick[1] = (clkSel[1] == CLKSEL_00) ? tickDivB0 :
                          (clkSel[1] == CLKSEL_01) ? tickDivB1 :
                          (clkSel[1] == CLKSEL_10) ? riseEdge[1] :
                                                     fallEdge[1];
    // The forbidden code gives no count clock at all.
    assign countTick[2] = (clkSel[2] == CLKSEL_00) ? tickDivC0 :
                          (clkSel[2] == CLKSEL_01) ? tickDivC1 :
                          (clkSel[2] == CLKSEL_10) ? riseEdge[2] :
                                                     1'b0;

    wire logic [7:0] compareValue [NUM_TIMERS];
    assign compareValue[0] = compareValueA;
    assign compareValue[1] = compareValueB;
    assign compareValue[2] = compareValueC;

    // Free-running prescaler on the main clock.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prescaleReg <= '0;
        end else begin
            prescaleReg <= prescaleReg + 1'b1;
        end
    end

    // Two-flop synchronisers plus one stage for edge detection.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncStage1Reg <= 3'h0;
            syncStage2Reg <= 3'h0;
            syncStage3Reg <= 3'h0;
        end else begin
            syncStage1Reg <= {subClockInput, timerBEventInput,
                              timerAEventInput};
            syncStage2Reg <= syncStage1Reg;
            syncStage3Reg <= syncStage2Reg;
        end
    end

    // Registered read data, updated on each read strobe.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readDataReg <= 8'h00;
        end else if (readStrobe) begin
            readDataReg <= readSelect;
        end
    end

    genvar t;
    generate
        for (t = 0; t < NUM_TIMERS; t++) begin : gTimer
            wire logic       runEnable;
            wire logic       pwmSelect;
            wire logic       outEnable;
            wire logic       isMatch;
            wire logic       isWrap;
            wire logic [7:0] byteNext;
            wire logic [7:0] bitNext;
            wire logic [7:0] modeNext;
            assign runEnable = modeReg[t][RUN_ENABLE_BIT];
            assign pwmSelect = modeReg[t][PWM_SELECT_BIT];
            assign outEnable = modeReg[t][OUTPUT_ENABLE_BIT];
            assign isMatch   = runEnable && countTick[t] &&
                               (countReg[t] == compareValue[t]);
            assign isWrap    = runEnable && countTick[t] &&
                               (countReg[t] == COUNT_TOP);

            // Byte store or single-bit store; absent bits stay zero.
            assign byteNext = byteData & MODE_WRITE_MASK;
            assign bitNext  = bitValue ?
                (modeReg[t] | (8'h01 << bitIndex)) & MODE_WRITE_MASK :
                (modeReg[t] & ~(8'h01 << bitIndex));
            assign modeNext = byteWrite ? byteNext : bitNext;

            // Mode control register with reset to zero.
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    modeReg[t] <= MODE_RESET;
                end else if (addrHit[t] && (byteWrite || bitWrite)) begin
                    modeReg[t] <= modeNext;
                end
            end

            // Counter: cleared while stopped; PWM mode runs the full range.
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    countReg[t] <= COUNT_RESET;
                end else if (!runEnable) begin
                    countReg[t] <= COUNT_RESET;
                end else if (isMatch && !pwmSelect) begin
                    countReg[t] <= COUNT_RESET;
                end else if (countTick[t]) begin
                    countReg[t] <= countReg[t] + 1'b1;
                end
            end

            // Match request pulse and timer output stage.
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    matchIrqReg[t] <= 1'b0;
                    timerOutReg[t] <= 1'b0;
                end else begin
                    matchIrqReg[t] <= isMatch;
                    if (!runEnable) begin
                        timerOutReg[t] <= 1'b0;
                    end else if (pwmSelect) begin
                        // High from wrap until match, low after.
                        if (isMatch) begin
                            timerOutReg[t] <= 1'b0;
                        end else if (isWrap) begin
                            timerOutReg[t] <= 1'b1;
                        end
                    end else if (isMatch) begin
                        timerOutReg[t] <= ~timerOutReg[t];
                    end
                end
            end

            // Shared pin: timer output when enabled, else port value.
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pinOutReg[t] <= 1'b0;
                end else begin
                    pinOutReg[t] <= outEnable ? timerOutReg[t]
                                              : portPinValue[t];
                end
            end

            // Pin drive enable, active low while the timer owns the pin.
            assign pinOutEnable_n[t] = ~outEnable;
        end
    endgenerate

    // Output assignments from registers.
    assign readData       = readDataReg;
    assign countRegisterA = countReg[0];
    assign countRegisterB = countReg[1];
    assign countRegisterC = countReg[2];
    assign matchIrq       = matchIrqReg;
    assign pinOut         = pinOutReg;

endmodule

//--- triple_timer_pkg.sv
/*
 * Shared constants for the three-timer mode control block: register
 * addresses, field positions, reset values and count clock encodings.
 * Assumes a byte-wide processor data path with a 16-bit address.
 */
package triple_timer_pkg;

    localparam int          NUM_TIMERS        = 3;
    localparam int          ADDR_WIDTH        = 16;

    // Mode control register addresses on the processor data path.
    localparam logic [15:0] TIMER_A_MODE_ADDR = 16'hFF53;
    localparam logic [15:0] TIMER_B_MODE_ADDR = 16'hFF57;
    localparam logic [15:0] TIMER_C_MODE_ADDR = 16'hFF5B;

    // Field positions inside each mode control register.
    localparam int          RUN_ENABLE_BIT    = 7;
    localparam int          PWM_SELECT_BIT    = 6;
    localparam int          CLKSEL_HI_BIT     = 2;
    localparam int          CLKSEL_LO_BIT     = 1;
    localparam int          OUTPUT_ENABLE_BIT = 0;

    // Reset value and the mask of bits that exist in hardware.
    localparam logic [7:0]  MODE_RESET        = 8'h00;
    localparam logic [7:0]  MODE_WRITE_MASK   = 8'hC7;
    localparam logic [7:0]  COUNT_RESET       = 8'h00;
    localparam logic [7:0]  COUNT_TOP         = 8'hFF;

    // Count clock selection codes.
    localparam logic [1:0]  CLKSEL_00         = 2'h0;
    localparam logic [1:0]  CLKSEL_01         = 2'h1;
    localparam logic [1:0]  CLKSEL_10         = 2'h2;
    localparam logic [1:0]  CLKSEL_11         = 2'h3;

    // Prescaler taps as powers of two of the main clock.
    localparam int          PRESCALE_WIDTH    = 8;
    localparam int          DIV_A_LOG2        = 3;
    localparam int          DIV_B0_LOG2       = 4;
    localparam int          DIV_B1_LOG2       = 8;
    localparam int          DIV_C0_LOG2       = 5;
    localparam int          DIV_C1_LOG2       = 7;

endpackage
